// [common/tone_pkg.sv]
package tone_pkg;

  // clock rates in hertz; every divide below follows from them
  localparam int SYS_HZ = 40_000_000;
  localparam int REF_HZ = 1_950_000;
  localparam int CNT_HZ = 3_900_000;
  localparam int REF_DIV = SYS_HZ / REF_HZ;
  localparam int CNT_DIV = SYS_HZ / CNT_HZ;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_DUTY = 4'h2;
  localparam logic [3:0] IDX_DIV  = 4'h4;
  localparam logic [3:0] IDX_CNT  = 4'h6;
  localparam logic [3:0] IDX_PAT  = 4'h8;
  localparam logic [9:0] IDX_ALTSEL = 10'h020;
  localparam int CH_BIT = 4;

  // field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_LIVE_BIT = 1;
  localparam int ALTSEL_BIT    = 0;

  // reset values
  localparam logic [7:0]  LIMIT_RST = 8'h64;
  localparam logic [7:0]  DUTY_RST  = 8'h32;
  localparam logic [9:0]  DIV_RST   = 10'h0fa;
  localparam logic [31:0] PAT_RST   = 32'hf0f0f0f0;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_WAIT = 2'b01,
    APB_DONE = 2'b10
  } apb_state_e;

  // settings of one generator
  typedef struct packed {
    logic        enable;
    logic        live_read;
    logic [7:0]  duty;
    logic [7:0]  limit;
    logic [9:0]  divide;
    logic [31:0] pattern;
  } chan_cfg_s;

  // state that one generator shows back
  typedef struct packed {
    logic        tone_out;
    logic [31:0] shift;
  } chan_stat_s;

endpackage

// [rtl/annunciator_pwm.sv]
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - buzzer reaches pin only when select set
// - two generators alternated at reference rate
// - divided reference clock makes the tone train
// - duty-programmable carrier near 39 kHz sets volume
// - 8-bit counter steps to limit minus one, wraps
// - counter limit resets to one hundred
// - writable 8-bit duty threshold register
// - carrier high while counter not above duty
// - 10-bit divider register clocks the pattern
// - pattern latch loads the shift register
// - shift output is tone, recirculates
// - generator output is carrier AND tone
// - control bit 0 enables the generator
// - control bit 1 selects live pattern reads
module annunciator_pwm
  import tone_pkg::*;
#(
  parameter int NCH = 2
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        gpio_c4_level,
  output logic             pin_c4_level
);

  // shared timing strobes
  // both generators see the same strobes, so their steps line up

  logic ref_tick;
  logic cnt_tick;

  // reference strobe steps dividers and the alternation
  tick_gen #(
    .DIVIDE (REF_DIV)
  ) u_ref_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (ref_tick)
  );

  // counter strobe stands in for a separate counter clock,
  // which keeps the whole block in one domain
  tick_gen #(
    .DIVIDE (CNT_DIV)
  ) u_cnt_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (cnt_tick)
  );

  // bus state and decode
  // word map: ctrl 0x00, duty 0x02, divider 0x04, limit 0x06,
  // pattern 0x08, second generator at +0x10, pin select at 0x20

  apb_state_e  state_r;
  apb_state_e  state_nxt;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        altsel_r;
  logic        pin_r;
  logic        phase_r;

  chan_cfg_s   cfg_r  [NCH];
  chan_stat_s  stat_w [NCH];

  // index and sub-decode of the word address
  wire [9:0] idx      = paddr[11:2];
  wire       aligned  = (paddr[1:0] == 2'b00);
  wire       in_chan  = (idx[9:5] == 5'h00);
  wire       chan_sel = idx[CH_BIT];
  wire [3:0] sub      = idx[3:0];

  // which register the current address names
  wire hit_ctrl   = aligned && in_chan && (sub == IDX_CTRL);
  wire hit_duty   = aligned && in_chan && (sub == IDX_DUTY);
  wire hit_div    = aligned && in_chan && (sub == IDX_DIV);
  wire hit_cnt    = aligned && in_chan && (sub == IDX_CNT);
  wire hit_pat    = aligned && in_chan && (sub == IDX_PAT);
  wire hit_altsel = aligned && (idx == IDX_ALTSEL);
  wire hit_any    = hit_ctrl | hit_duty | hit_div | hit_cnt |
                    hit_pat | hit_altsel;

  // access phase seen for the first time, and its completion
  wire access     = psel && penable;
  wire take       = access && (state_r == APB_IDLE);
  wire commit     = access && (state_r == APB_WAIT);
  wire wr_commit  = commit && pwrite && hit_any;

  // bus handshake: one wait state so read data come from a flop
  // costs a cycle per access but keeps prdata off the decode path

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      APB_IDLE: begin
        if (take) state_nxt = APB_WAIT;
      end
      APB_WAIT: begin
        if (commit) state_nxt = APB_DONE;
      end
      APB_DONE: begin
        state_nxt = APB_IDLE;
      end
      default: begin
        state_nxt = APB_IDLE;
      end
    endcase
  end

  // byte-lane merge for partial writes
  // lanes with pstrb low keep their old contents

  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = new_v[8*b +: 8];
    end
    return res;
  endfunction

  // read data selection
  // narrow registers sit in the low bits, the rest reads zero

  chan_cfg_s  rd_cfg;
  chan_stat_s rd_stat;
  logic [31:0] rd_word;

  assign rd_cfg  = cfg_r[chan_sel];
  assign rd_stat = stat_w[chan_sel];

  // live pattern view tracks the shift register as it rotates
  wire [31:0] pat_view = rd_cfg.live_read ? rd_stat.shift
                         : rd_cfg.pattern;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_word[CTRL_EN_BIT]   = rd_cfg.enable;
      rd_word[CTRL_LIVE_BIT] = rd_cfg.live_read;
    end else if (hit_duty) begin
      rd_word[7:0] = rd_cfg.duty;
    end else if (hit_div) begin
      rd_word[9:0] = rd_cfg.divide;
    end else if (hit_cnt) begin
      rd_word[7:0] = rd_cfg.limit;
    end else if (hit_pat) begin
      rd_word = pat_view;
    end else if (hit_altsel) begin
      rd_word[ALTSEL_BIT] = altsel_r;
    end
  end

  // bus answer flops
  // every answer signal leaves the block straight from a flop

  // handshake state loads its next value on every edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= APB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pready pulses for exactly the completing access cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= take;
      pslverr_r <= take && !hit_any;
    end
  end

  // read data captured once and then held, so a late sample of
  // prdata never sees a value that is still moving
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (take && !pwrite) begin
      prdata_r <= rd_word;
    end
  end

  // per-generator settings
  // a generator's settings change only on its own addresses

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    wire        mine  = wr_commit && (chan_sel == 1'(c));
    wire [31:0] cur_c = {30'h0, cfg_r[c].live_read, cfg_r[c].enable};
    wire [31:0] wr_c  = merge(cur_c, pwdata, pstrb);
    wire [31:0] wr_d  = merge({24'h0, cfg_r[c].duty}, pwdata, pstrb);
    wire [31:0] wr_v  = merge({22'h0, cfg_r[c].divide}, pwdata, pstrb);
    wire [31:0] wr_l  = merge({24'h0, cfg_r[c].limit}, pwdata, pstrb);
    wire [31:0] wr_p  = merge(cfg_r[c].pattern, pwdata, pstrb);

    // each instance has its own settings, written independently
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        cfg_r[c].enable    <= 1'b0;
        cfg_r[c].live_read <= 1'b0;
        cfg_r[c].duty      <= DUTY_RST;
        cfg_r[c].limit     <= LIMIT_RST;
        cfg_r[c].divide    <= DIV_RST;
        cfg_r[c].pattern   <= PAT_RST;
      end else if (mine) begin
        if (hit_ctrl) begin
          cfg_r[c].enable    <= wr_c[CTRL_EN_BIT];
          cfg_r[c].live_read <= wr_c[CTRL_LIVE_BIT];
        end
        if (hit_duty) cfg_r[c].duty <= wr_d[7:0];
        if (hit_div) cfg_r[c].divide <= wr_v[9:0];
        if (hit_cnt) cfg_r[c].limit <= wr_l[7:0];
        if (hit_pat) cfg_r[c].pattern <= wr_p;
      end
    end

    // one carrier/tone generator per set of settings
    tone_channel u_chan (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .cnt_tick (cnt_tick),
      .ref_tick (ref_tick),
      .cfg      (cfg_r[c]),
      .stat     (stat_w[c])
    );
  end

  // pin function select
  // select resets to zero, so the pin starts as a plain level

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      altsel_r <= 1'b0;
    end else if (wr_commit && hit_altsel && pstrb[0]) begin
      altsel_r <= pwdata[ALTSEL_BIT];
    end
  end

  // alternation and pin drive
  // one extra cycle of lag on the pin, in exchange for a clean flop

  // the two outputs take turns, one reference period each; the
  // external filter averages them, so both tones can sound at once
  wire annunciator = phase_r ? stat_w[1].tone_out
                     : stat_w[0].tone_out;

  // general-purpose level passes unless the buzzer is selected
  wire pin_nxt = altsel_r ? annunciator : gpio_c4_level;

  // phase flips on every reference strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_r <= 1'b0;
    end else if (ref_tick) begin
      phase_r <= ~phase_r;
    end
  end

  // pin level comes from a flop, glitch-free for the driver
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // outputs, all from flops
  // no logic between these flops and the ports

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign pin_c4_level = pin_r;

endmodule

// [rtl/tick_gen.sv]
`timescale 1ns/1ps
module tick_gen #(
  parameter int DIVIDE = 10
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      tick
);
  localparam int W = (DIVIDE > 2) ? $clog2(DIVIDE) : 1;
  localparam logic [W-1:0] LAST = W'(DIVIDE - 1);

  logic [W-1:0] cnt_r;
  logic         tick_r;
  wire          wrap = (cnt_r == LAST);

  // one-cycle strobe every DIVIDE system clocks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= wrap ? '0 : cnt_r + W'(1);
      tick_r <= wrap;
    end
  end

  assign tick = tick_r;
endmodule

// [rtl/tone_channel.sv]
`timescale 1ns/1ps
module tone_channel
  import tone_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       cnt_tick,
  input  wire logic       ref_tick,
  input  wire chan_cfg_s  cfg,
  output chan_stat_s      stat
);
  logic [7:0]  count_r;
  logic [9:0]  div_r;
  logic [31:0] shift_r;
  logic        out_r;

  // carrier counter wraps so the period equals the limit value
  wire [8:0] count_inc = {1'b0, count_r} + 9'h001;
  wire [7:0] count_nxt = (count_inc >= {1'b0, cfg.limit}) ? 8'h00
                         : count_inc[7:0];
  wire       carrier   = (count_r <= cfg.duty);
  // a divide of zero or one steps the pattern every reference tick
  wire       div_last  = (cfg.divide <= 10'h001) ||
                         (div_r == cfg.divide - 10'h001);
  wire [9:0] div_nxt   = div_last ? 10'h000 : div_r + 10'h001;
  wire       tone      = shift_r[31];

  // disabled: hold low and keep everything ready to restart cleanly
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_r <= 8'h00;
      div_r   <= 10'h000;
      shift_r <= PAT_RST;
      out_r   <= 1'b0;
    end else if (!cfg.enable) begin
      count_r <= 8'h00;
      div_r   <= 10'h000;
      shift_r <= cfg.pattern;
      out_r   <= 1'b0;
    end else begin
      if (cnt_tick) count_r <= count_nxt;
      if (ref_tick) div_r <= div_nxt;
      if (ref_tick && div_last)
        shift_r <= {shift_r[30:0], shift_r[31]};
      out_r <= carrier & tone;
    end
  end

  assign stat.tone_out = out_r;
  assign stat.shift    = shift_r;
endmodule

// [verif/annunciator_pwm_properties.sv]
`timescale 1ns/1ps
module annunciator_pwm_properties #(
  parameter int NCH = 2
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        gpio_c4_level,
  input wire logic        pin_c4_level
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       sel_r;
  logic       en1_r;
  logic       en2_r;
  logic [2:0] idle_r;
  logic [2:0] idle_nxt;
  wire        wr_lo = psel & penable & pready & pwrite & pstrb[0];
  // idle count saturates, so only a long quiet spell arms the check
  assign idle_nxt = (en1_r | en2_r) ? 3'h0 :
                    (idle_r == 3'h7) ? 3'h7 : idle_r + 3'h1;
  // shadows of select and enables, updated on the same edge as the
  // registers they mirror
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_r  <= 1'b0;
      en1_r  <= 1'b0;
      en2_r  <= 1'b0;
      idle_r <= 3'h0;
    end else begin
      if (wr_lo && paddr == 12'h080) sel_r <= pwdata[0];
      if (wr_lo && paddr == 12'h000) en1_r <= pwdata[0];
      if (wr_lo && paddr == 12'h040) en2_r <= pwdata[0];
      idle_r <= idle_nxt;
    end
  end
  acc_wait_a: assert property (
    psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not one cycle after access start");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_zero_a: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  unaligned_err_a: assert property (
    pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  mapped_ok_a: assert property (pready && paddr == 12'h008 |-> !pslverr)
    else $error("mapped access refused");
  read_hold_a: assert property (
    !$stable(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  gpio_path_a: assert property (
    !$past(rst, 2) && !$past(sel_r) |-> pin_c4_level == $past(gpio_c4_level))
    else $error("pin not following gpio level");
  idle_low_a: assert property (
    sel_r && $past(sel_r) && idle_r == 3'h7 |-> !pin_c4_level)
    else $error("pin high with both generators off");
  cover property (pready && pslverr);
  cover property (sel_r && en1_r && en2_r && pin_c4_level);
  cover property (pready && !pwrite && !pslverr);
endmodule

bind annunciator_pwm annunciator_pwm_properties #(.NCH(NCH)) u_props (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gpio_c4_level(gpio_c4_level), .pin_c4_level(pin_c4_level));

// [verif/buzzer_model.sv]
`timescale 1ns/1ps
// buzzer behind its driver only sees the pin level; it integrates
// the time the pin was high since the last clear
module buzzer_model (
  input  wire logic clk_sys,
  input  wire logic clr,
  input  wire logic pin_c4_level,
  output int        high_cnt
);
  always @(posedge clk_sys) begin
    if (clr) high_cnt <= 0;
    else high_cnt <= high_cnt + int'(pin_c4_level);
  end
endmodule

// [verif/tb_annunciator_pwm_tone_generator.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_annunciator_pwm_tone_generator;
  import tone_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        gpio_c4_level = 1'b0;
  logic        clr = 1'b1;
  logic [31:0] prdata, rd, r1, d;
  logic [31:0] seed = 32'h7263331a;
  logic [31:0] gseed = 32'h7263331a;
  logic        pready, pslverr, pin_c4_level, er;
  logic [11:0] a;
  bit          skip = 1'b0;
  int          fails = 0;
  int          checked = 0;
  int          high_cnt;
  logic [31:0] mdl[int];
  logic [11:0] adr[13] = '{12'h000, 12'h008, 12'h010, 12'h018, 12'h020,
    12'h040, 12'h048, 12'h050, 12'h058, 12'h060, 12'h080, 12'h0fc, 12'h00a};
  logic [31:0] rv[5] = '{32'h0, {24'h0, DUTY_RST}, {22'h0, DIV_RST},
    32'h64, PAT_RST};

  annunciator_pwm #(.NCH(2)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_c4_level(gpio_c4_level),
    .pin_c4_level(pin_c4_level));
  buzzer_model u_buzz (.clk_sys(clk_sys), .clr(clr),
    .pin_c4_level(pin_c4_level), .high_cnt(high_cnt));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // implemented bits per register; zero marks a refused address
  function automatic logic [31:0] msk(input logic [11:0] x);
    case (x & 12'hfbf)
      12'h000: return 32'h3;
      12'h008: return 32'hff;
      12'h010: return 32'h3ff;
      12'h018: return 32'hff;
      12'h020: return 32'hffffffff;
      12'h080: return 32'h1;
      default: return 32'h0;
    endcase
  endfunction

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // general-purpose level is random every cycle
  always @(posedge clk_sys) begin
    gseed <= nxt(gseed);
    gpio_c4_level <= gseed[0];
  end

  // one apb transfer, then the reference model is updated or compared
  task automatic acc(input logic w, input logic [11:0] ad,
                     input logic [31:0] dt, input logic [3:0] s);
    logic [31:0] m, be;
    int n;
    m = msk(ad);
    be = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    // hold everything until the edge that samples pready high
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(n, 1)
    `CHK(er, m == 32'h0)
    if (!w && !skip) `CHK(rd, (m == 32'h0) ? 32'h0 : mdl[ad])
    else if (w && m != 32'h0) mdl[ad] = (mdl[ad] & ~(be & m)) | (dt & be & m);
  endtask

  // same settings into both generators; pattern only lands while off
  task automatic prog(input logic [31:0] p, input logic [7:0] l, du,
                      input logic [9:0] dv, input logic [31:0] c);
    for (int b = 0; b < 128; b += 64) begin
      acc(1'b1, 12'(b), 32'h0, 4'hf);
      acc(1'b1, 12'(b + 32), p, 4'hf);
      acc(1'b1, 12'(b + 24), {24'h0, l}, 4'hf);
      acc(1'b1, 12'(b + 8), {24'h0, du}, 4'hf);
      acc(1'b1, 12'(b + 16), {22'h0, dv}, 4'hf);
      acc(1'b1, 12'(b), c, 4'hf);
    end
  endtask

  task automatic meas(input int n, input int ex, input int tol);
    repeat (8) @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(high_cnt >= ex - tol && high_cnt <= ex + tol, 1'b1)
  endtask

  task automatic give_verdict;
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // expected run is near 7.3k cycles; nearly seven times that is a hang
  initial begin
    #1_250_000;
    fails++;
    give_verdict;
  end

  initial begin
    foreach (adr[i]) mdl[adr[i]] = (i < 10) ? rv[i % 5] : 32'h0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    clr <= 1'b0;
    foreach (adr[i]) acc(1'b0, adr[i], 32'h0, 4'h0);
    // random data and lanes, each write read back
    repeat (40) begin
      seed = nxt(seed);
      a = adr[seed[7:0] % 13];
      d = nxt(seed);
      if (a[5:0] == 6'h0) d[1] = 1'b0; // live view checked apart
      acc(1'b1, a, d, seed[11:8]);
      acc(1'b0, a, 32'h0, 4'h0);
    end
    // live view: 604 cycles at 60 per step turns it left 10 or 11
    prog(32'h000100f1, 8'd10, 8'd3, 10'd3, 32'h3);
    skip = 1'b1;
    acc(1'b0, 12'h020, 32'h0, 4'h0);
    r1 = rd;
    repeat (600) @(posedge clk_sys);
    acc(1'b0, 12'h020, 32'h0, 4'h0);
    skip = 1'b0;
    `CHK(rd == {r1[21:0], r1[31:22]} || rd == {r1[20:0], r1[31:21]}, 1'b1)
    acc(1'b1, 12'h000, 32'h2, 4'hf);
    acc(1'b0, 12'h020, 32'h0, 4'h0);
    acc(1'b1, 12'h080, 32'h1, 4'h1);
    prog(32'hffffffff, 8'd10, 8'd9, 10'd1, 32'h1);
    meas(1000, 1000, 0);
    prog(32'hffffffff, 8'd10, 8'd3, 10'd1, 32'h1);
    meas(2000, 800, 20);
    prog(32'h0000ffff, 8'd10, 8'd9, 10'd2, 32'h1);
    meas(2560, 1280, 40);
    prog(32'hffffffff, 8'd10, 8'd9, 10'd1, 32'h0);
    meas(500, 0, 0);
    give_verdict;
  end
endmodule
